// File: pkg/lfsa_consts.vh
`ifndef LFSA_CONSTS_VH
`define LFSA_CONSTS_VH

// ----------------------------------------------------------------------
// Reset values of the nonvolatile bytes.
// ----------------------------------------------------------------------
`define LFSA_LOCK_RST      8'hFF
`define LFSA_FUSE_LOW_RST  8'h62
`define LFSA_FUSE_HIGH_RST 8'hDF
`define LFSA_FUSE_EXT_RST  8'hFF

// ----------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------
`define LFSA_LOCK_LOW_BIT   0
`define LFSA_LOCK_HIGH_BIT  1
`define LFSA_DIV8_BIT       7
`define LFSA_CLOCK_OUTPUT_FUSE_BIT      6
`define LFSA_SUT_MSB        5
`define LFSA_SUT_LSB        4
`define LFSA_CLOCK_SOURCE_FUSE_MSB      3
`define LFSA_CLOCK_SOURCE_FUSE_LSB      0
`define LFSA_PRESERVE_BIT   3
`define LFSA_SELFPRG_BIT    0

// ----------------------------------------------------------------------
// Serial link command codes.
// ----------------------------------------------------------------------
`define LFSA_CMD_ERASE    8'h80
`define LFSA_CMD_WR_MEM   8'h40
`define LFSA_CMD_RD_MEM   8'h20
`define LFSA_CMD_WR_FUSE  8'hA0
`define LFSA_CMD_RD_FUSE  8'h50
`define LFSA_CMD_WR_LOCK  8'hE0
`define LFSA_CMD_RD_LOCK  8'h58
`define LFSA_CMD_RD_SIG   8'h30

// ----------------------------------------------------------------------
// Register offsets on the CPU port.
// ----------------------------------------------------------------------
`define LFSA_REG_STATUS    3'h0
`define LFSA_REG_FUSE_LOW  3'h1
`define LFSA_REG_FUSE_HIGH 3'h2
`define LFSA_REG_FUSE_EXT  3'h3
`define LFSA_REG_LOCK      3'h4
`define LFSA_REG_SIG0      3'h5
`define LFSA_REG_SIG1      3'h6
`define LFSA_REG_SIG2      3'h7

`endif

// File: tb/lfsa_prog_model.sv
// ----------------------------------------------------------------------
// Serial programmer model: four-byte frames, reply from the last byte.
// ----------------------------------------------------------------------
module lfsa_prog_model (
	input  wire logic       clk_i,   // System clock.
	input  wire logic       miso_i,  // Data from device.
	output logic            sck_o,   // Serial clock.
	output logic            mosi_o,  // Data to device.
	output logic      [7:0] rep_o,   // Reply byte of last frame.
	output logic            rep_v_o  // Pulse: reply is ready.
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		sck_o = 1'b0;
		mosi_o = 1'b0;
		rep_o = 8'h00;
		rep_v_o = 1'b0;
	end

	// Sends one frame MSB first; clock halves of four cycles each.
	task automatic frame(input logic [31:0] f);
		int i;
		logic [7:0] rx;
		rx = 8'h00;
		for (i = 31; i >= 0; i--) begin
			mosi_o <= f[i];
			repeat (4) @(posedge clk_i);
			sck_o <= 1'b1;
			if (i < 8) rx = {rx[6:0], miso_i};
			repeat (4) @(posedge clk_i);
			sck_o <= 1'b0;
		end
		repeat (4) @(posedge clk_i);
		mosi_o <= ~f[0];
		rep_o <= rx;
		rep_v_o <= 1'b1;
		@(posedge clk_i);
		rep_v_o <= 1'b0;
	endtask
endmodule // lfsa_prog_model

// File: tb/lfsa_top_props.sv
// ----------------------------------------------------------------------
// Port checker for the lock and fuse access block.
// ----------------------------------------------------------------------
module lfsa_top_props (
	input wire       mclk_i,       // System clock.
	input wire       arst_n_i,     // Reset, active low.
	input wire       prog_mode_i,  // Programming mode.
	input wire       reg_rd_i,     // CPU read strobe.
	input wire [7:0] reg_rdata_o,  // CPU read data.
	input wire       mem_wr_o,     // Memory write pulse.
	input wire       mem_rd_o,     // Memory read pulse.
	input wire       mem_erase_o,  // Erase pulse.
	input wire       miso_oe_n_o,  // Data out enable, active low.
	input wire       clk_div8_o,   // Latched divide fuse.
	input wire [1:0] startup_o,    // Latched start-up time.
	input wire [3:0] clk_src_o,    // Latched clock source.
	input wire       clkout_en_o,  // Clock output enable.
	input wire       spm_en_o,     // Store instruction enable.
	input wire [1:0] prot_level_o  // Protection level.
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!arst_n_i);

	// ----------------------------------------------------------------
	// Assertions.
	// ----------------------------------------------------------------
	AST_LVL_DROP: assert property (
		(prot_level_o < $past(prot_level_o)) |-> ($past(mem_erase_o) ||
		$past(mem_erase_o, 2) || $past(mem_erase_o, 3)))
		else $error("protection relaxed without erase");
	AST_WR_LVL: assert property (
		mem_wr_o |-> prot_level_o == 2'h1)
		else $error("memory write while locked");
	AST_PULSE_PROG: assert property (
		(mem_wr_o || mem_rd_o || mem_erase_o) |-> $past(prog_mode_i))
		else $error("memory pulse outside programming mode");
	AST_HOLD: assert property (
		prog_mode_i && $past(prog_mode_i, 2) |-> $stable({clk_div8_o,
		startup_o, clk_src_o, clkout_en_o, spm_en_o}))
		else $error("latched fuse moved in programming mode");
	AST_LIVE_EXIT: assert property (
		!$stable({clk_div8_o, startup_o, clk_src_o, clkout_en_o}) |->
		!prog_mode_i && ($past(prog_mode_i) || $past(prog_mode_i, 2) ||
		$past(prog_mode_i, 3)))
		else $error("latched fuse moved outside exit");
	AST_SPM: assert property (
		$changed(spm_en_o) |-> !prog_mode_i && ($past(prog_mode_i) ||
		$past(prog_mode_i, 2) || $past(prog_mode_i, 3)))
		else $error("store enable moved outside exit");
	AST_OE: assert property (
		miso_oe_n_o == !$past(prog_mode_i))
		else $error("data out enable wrong");
	AST_ERASE_PULSE: assert property (
		mem_erase_o |=> !mem_erase_o [*4])
		else $error("erase pulse too long");
	AST_RD_IDLE: assert property (
		!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
		else $error("read data outside its cycle");

	// Main scenarios reached.
	cover property (mem_erase_o);
	cover property (prot_level_o == 2'h3);
	cover property (mem_wr_o);
endmodule // lfsa_top_props

// File: tb/lfsa_top_tb.sv
module lfsa_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam [7:0] S0 = 8'h6B; // Arbitrary identification value.
	localparam [7:0] S1 = 8'hC4; // Arbitrary identification value.
	localparam [7:0] S2 = 8'h19; // Arbitrary identification value.
	logic mclk_i, arst_n_i, prog_mode_i, reg_wr_i, reg_rd_i, rd_q, rep_v;
	logic sck, mosi, miso_o, miso_oe_n_o, mem_wr_o, mem_rd_o, mem_erase_o;
	logic clk_div8_o, clkout_en_o, spm_en_o, ee_preserve_o;
	logic [1:0] startup_o, prot_level_o;
	logic [3:0] clk_src_o;
	logic [2:0] reg_addr_i;
	logic [7:0] reg_wdata_i, mem_rdata_i, reg_rdata_o, mem_addr_o;
	logic [7:0] mem_wdata_o, rep, fv, md;
	logic [8:0] n;
	logic [7:0] cq[$];
	logic [8:0] sq[$];
	int num_errors = 0, cmp_count = 0, wr_cnt = 0, er_cnt = 0, rd_cnt = 0, k;

	lfsa_top #(.SIG0(S0), .SIG1(S1), .SIG2(S2)) dut (
		.mclk_i(mclk_i), .arst_n_i(arst_n_i), .prog_mode_i(prog_mode_i),
		.sck_i(sck), .mosi_i(mosi), .miso_o(miso_o),
		.miso_oe_n_o(miso_oe_n_o), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
		.mem_wr_o(mem_wr_o), .mem_rd_o(mem_rd_o),
		.mem_rdata_i(mem_rdata_i), .mem_erase_o(mem_erase_o),
		.clk_div8_o(clk_div8_o), .clkout_en_o(clkout_en_o),
		.startup_o(startup_o), .clk_src_o(clk_src_o),
		.spm_en_o(spm_en_o), .ee_preserve_o(ee_preserve_o),
		.prot_level_o(prot_level_o));

	lfsa_prog_model prog (.clk_i(mclk_i),
		.miso_i(miso_oe_n_o ? 1'bz : miso_o), .sck_o(sck),
		.mosi_o(mosi), .rep_o(rep), .rep_v_o(rep_v));

	// System clock, 50 ns period.
	initial begin
		mclk_i = 1'b0;
		forever #25 mclk_i = ~mclk_i;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: saw %h, expected %h", $time,
				seen, exp);
		end
	endtask

	task automatic wrap_up();
		if (num_errors == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic do_reset();
		arst_n_i <= 1'b0;
		repeat (20) @(posedge mclk_i);
		arst_n_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
	endtask

	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		cq.push_back(e);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge mclk_i);
		reg_rd_i <= 1'b0;
		@(posedge mclk_i);
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge mclk_i);
		reg_wr_i <= 1'b0;
		@(posedge mclk_i);
	endtask

	// One serial frame; bit 8 of the note asks for a reply check.
	task automatic ser(input logic [7:0] c, a, d, input logic [8:0] e);
		sq.push_back(e);
		prog.frame({c, a, d, 8'h00});
	endtask

	// Watches read data, replies and memory pulses.
	always @(posedge mclk_i) begin
		if (rd_q) check(reg_rdata_o, cq.pop_front());
		rd_q <= reg_rd_i;
		if (rep_v) begin
			n = sq.pop_front();
			if (n[8]) check(rep, n[7:0]);
		end
		if (mem_wr_o) wr_cnt++;
		if (mem_rd_o) rd_cnt++;
		if (mem_erase_o) er_cnt++;
	end

	// Cuts a hang short.
	initial begin
		repeat (20000) @(posedge mclk_i);
		num_errors++;
		wrap_up();
	end

	// Main sequence.
	initial begin
		{arst_n_i, prog_mode_i, reg_wr_i, reg_rd_i} = 4'h0;
		{reg_addr_i, reg_wdata_i, mem_rdata_i} = 19'h00000;
		k = $urandom(32'h4710);
		fv = 8'($urandom) & 8'hBF | 8'h80;
		md = 8'($urandom) | 8'h01;
		do_reset();
		check(8'(prot_level_o), 8'h01);
		check({clk_div8_o, clkout_en_o, startup_o, clk_src_o}, 8'h22);
		check(8'(spm_en_o), 8'h00);
		rd(3'h4, 8'hFF);
		rd(3'h1, 8'h62);
		wr(3'h4, 8'h00);
		rd(3'h4, 8'hFF);
		rd(3'h5, S0);
		rd(3'h7, S2);
		prog_mode_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		ser(8'h30, 8'h00, 8'h00, {1'b1, S0});
		ser(8'h30, 8'h01, 8'h00, {1'b1, S1});
		ser(8'h30, 8'h02, 8'h00, {1'b1, S2});
		ser(8'hA0, 8'h00, fv, 9'h000);
		check(8'({clk_div8_o, clkout_en_o}), 8'h00);
		ser(8'h50, 8'h00, 8'h00, {1'b1, fv});
		ser(8'hA0, 8'h01, 8'hD7, 9'h000);
		check(8'(ee_preserve_o), 8'h01);
		ser(8'hA0, 8'h02, 8'hFE, 9'h000);
		ser(8'hE0, 8'h00, 8'hFE, 9'h000);
		check(8'(prot_level_o), 8'h02);
		mem_rdata_i <= md;
		ser(8'h40, 8'h05, 8'h33, 9'h101);
		ser(8'hA0, 8'h00, 8'h62, 9'h101);
		ser(8'h50, 8'h00, 8'h00, {1'b1, fv});
		ser(8'h20, 8'h07, 8'h00, {1'b1, md});
		ser(8'hE0, 8'h00, 8'hFF, 9'h000);
		ser(8'h58, 8'h00, 8'h00, 9'h1FE);
		ser(8'hE0, 8'h00, 8'hFC, 9'h000);
		check(8'(prot_level_o), 8'h03);
		ser(8'h20, 8'h07, 8'h00, 9'h100);
		check(8'(rd_cnt), 8'h01);
		rd(3'h0, 8'h0F);
		ser(8'h30, 8'h00, 8'h00, {1'b1, S0});
		check(8'(wr_cnt), 8'h00);
		prog_mode_i <= 1'b0;
		repeat (4) @(posedge mclk_i);
		check({clk_div8_o, clkout_en_o, startup_o, clk_src_o},
			{2'b11, fv[5:0]});
		check(8'(spm_en_o), 8'h01);
		rd(3'h2, 8'hD7);
		prog_mode_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		ser(8'h80, 8'h00, 8'h00, 9'h000);
		check(8'(er_cnt), 8'h01);
		ser(8'h58, 8'h00, 8'h00, 9'h1FF);
		check(8'(prot_level_o), 8'h01);
		ser(8'h40, 8'h09, 8'hA5, 9'h000);
		check(8'(wr_cnt), 8'h01);
		check(mem_addr_o ^ mem_wdata_o, 8'hAC);
		prog_mode_i <= 1'b0;
		wr(3'h4, 8'hFD);
		rd(3'h4, 8'hFD);
		check(8'(prot_level_o), 8'h03);
		do_reset();
		check({clk_div8_o, clkout_en_o, startup_o, clk_src_o}, 8'h22);
		check(8'(spm_en_o), 8'h00);
		wrap_up();
	end
endmodule // lfsa_top_tb

bind lfsa_top lfsa_top_props u_props (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
	.prog_mode_i(prog_mode_i), .reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o), .mem_wr_o(mem_wr_o), .mem_rd_o(mem_rd_o),
	.mem_erase_o(mem_erase_o), .miso_oe_n_o(miso_oe_n_o),
	.clk_div8_o(clk_div8_o), .startup_o(startup_o), .clk_src_o(clk_src_o),
	.clkout_en_o(clkout_en_o), .spm_en_o(spm_en_o),
	.prot_level_o(prot_level_o));

// File: verilog/lfsa_fuse_latch.v
// ----------------------------------------------------------------------
// One fuse byte: stored value and the copy the device acts on.
// ----------------------------------------------------------------------
module lfsa_fuse_latch #(
	parameter [7:0] RST = 8'hFF  // Reset image of the byte.
) (
	input  wire       mclk_i,    // System clock.
	input  wire       arst_n_i,  // Asynchronous reset, active low.
	input  wire       wr_i,      // Write the stored byte.
	input  wire [7:0] wdata_i,   // New stored value.
	input  wire       capture_i, // Copy stored value to live copy.
	output reg  [7:0] fuse_o,    // Stored value.
	output reg  [7:0] live_o     // Latched value in effect.
);

	// Writes change only the stored byte; the live copy follows on capture.
	always @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			fuse_o <= RST;
			live_o <= RST;
		end else begin
			if (wr_i) begin
				fuse_o <= wdata_i;
			end
			if (capture_i) begin
				live_o <= fuse_o;
			end
		end
	end

endmodule // lfsa_fuse_latch

// File: verilog/lfsa_spi_shift.v
// ----------------------------------------------------------------------
// Serial link shifter, oversampling the programmer clock.
// ----------------------------------------------------------------------
module lfsa_spi_shift (
	input  wire       mclk_i,      // System clock.
	input  wire       arst_n_i,    // Asynchronous reset, active low.
	input  wire       en_i,        // Link active (programming mode).
	input  wire       sck_i,       // Serial clock from programmer.
	input  wire       mosi_i,      // Serial data in.
	input  wire       load_i,      // Load next reply byte.
	input  wire [7:0] load_data_i, // Reply byte to shift out.
	output reg  [7:0] rx_data_o,   // Last received byte.
	output reg        done_o,      // Pulse: a byte was received.
	output reg        miso_o       // Serial data out.
);

	reg       sck_ff;
	reg [2:0] bit_cnt_ff;
	reg [7:0] rx_ff;
	reg [7:0] tx_ff;
	wire      rise;
	wire      fall;

	// Edges of the serial clock, seen only while the link is active.
	assign rise = en_i & sck_i & ~sck_ff;
	assign fall = en_i & ~sck_i & sck_ff;

	// Input sampled on rising edges, output shifted on falling edges.
	always @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sck_ff     <= 1'b0;
			bit_cnt_ff <= 3'h0;
			rx_ff      <= 8'h00;
			tx_ff      <= 8'h00;
			rx_data_o  <= 8'h00;
			done_o     <= 1'b0;
			miso_o     <= 1'b0;
		end else begin
			sck_ff <= sck_i;
			done_o <= rise & (bit_cnt_ff == 3'h7);
			if (!en_i) begin
				bit_cnt_ff <= 3'h0;
			end else if (rise) begin
				bit_cnt_ff <= bit_cnt_ff + 3'h1;
				rx_ff      <= {rx_ff[6:0], mosi_i};
				if (bit_cnt_ff == 3'h7) begin
					rx_data_o <= {rx_ff[6:0], mosi_i};
				end
			end
			// The fall closing a byte does not shift the next reply.
			if (load_i) begin
				miso_o <= load_data_i[7];
				tx_ff  <= {load_data_i[6:0], 1'b0};
			end else if (fall && bit_cnt_ff != 3'h0) begin
				miso_o <= tx_ff[7];
				tx_ff  <= {tx_ff[6:0], 1'b0};
			end
		end
	end

endmodule // lfsa_spi_shift

// File: verilog/lfsa_top.v
// The plain strobed port and the register offsets were left to the implementer.
`include "lfsa_consts.vh"

// Function
// - Lock byte, two active bits, defaults one
// - Programmed lock bits cleared only by erase; here arst_n_i also restores the lock byte to all ones
// - Level one: no restriction at all
// - Level two: refuse memory and fuse writes
// - Level three: also refuse memory verification
// - Fuse low byte layout and defaults
// - Self-program fuse enables store instruction
// - Clock output fuse routes system clock out
// - Fuses latched on programming entry, exit
// - Preserve fuse takes effect immediately
// - Fuses latched at power-up, normal mode
// - Read-only identification always readable
// - Identification at addresses zero to two
// - Sample on rising, shift on falling edge
module lfsa_top #(
	parameter [7:0] SIG0 = 8'h5A, // Maker code, arbitrary value.
	parameter [7:0] SIG1 = 8'hA1, // Memory size code, arbitrary value.
	parameter [7:0] SIG2 = 8'h3C  // Part code, arbitrary value.
) (
	input  wire       mclk_i,        // System clock, 20 MHz.
	input  wire       arst_n_i,      // Asynchronous reset, active low.
	input  wire       prog_mode_i,   // Programming mode is active.
	input  wire       sck_i,         // Serial clock from programmer.
	input  wire       mosi_i,        // Serial data from programmer.
	output wire       miso_o,        // Serial data to programmer.
	output reg        miso_oe_n_o,   // Data out enable, active low.
	input  wire [2:0] reg_addr_i,    // CPU register address.
	input  wire [7:0] reg_wdata_i,   // CPU write data.
	input  wire       reg_wr_i,      // CPU write strobe.
	input  wire       reg_rd_i,      // CPU read strobe.
	output reg  [7:0] reg_rdata_o,   // CPU read data, next cycle.
	output reg  [7:0] mem_addr_o,    // Memory address.
	output reg  [7:0] mem_wdata_o,   // Memory write data.
	output reg        mem_wr_o,      // Memory write pulse.
	output reg        mem_rd_o,      // Memory read pulse.
	input  wire [7:0] mem_rdata_i,   // Memory read data.
	output reg        mem_erase_o,   // Chip erase pulse.
	output wire       clk_div8_o,    // Divide clock by eight.
	output reg        clkout_en_o,   // Clock to output pin enable.
	output wire [1:0] startup_o,     // Start-up time select.
	output wire [3:0] clk_src_o,     // Clock source select.
	output reg        spm_en_o,      // Store instruction enabled.
	output reg        ee_preserve_o, // Keep data memory on erase.
	output reg  [1:0] prot_level_o   // Protection level, 1 to 3.
);

	// ------------------------------------------------------------------
	// Declarations.
	// ------------------------------------------------------------------
	localparam [23:0] FUSE_RST = {`LFSA_FUSE_EXT_RST,
		`LFSA_FUSE_HIGH_RST, `LFSA_FUSE_LOW_RST};

	reg  [7:0]  lock_ff;
	reg  [7:0]  nxt_lock;
	reg         pwrup_ff;
	reg         prog_ff;
	reg  [1:0]  idx_ff;
	reg  [7:0]  cmd_ff;
	reg  [7:0]  addr_ff;
	reg         refused_ff;
	reg         nxt_refused;
	reg  [7:0]  reply;
	reg  [2:0]  fuse_wr;
	reg         nxt_mem_wr;
	reg         nxt_erase;
	wire [23:0] fuse_st;
	wire [23:0] fuse_lv;
	wire [7:0]  rx_data;
	wire        done;
	wire        capture;
	wire        wr_ok;
	wire        rd_ok;
	wire        exec;

	// ------------------------------------------------------------------
	// Functions.
	// ------------------------------------------------------------------

	// Identification byte for an address; unused address reads zero.
	function [7:0] sig_byte;
		input [1:0] a;
		begin
			case (a)
				2'h0:    sig_byte = SIG0;
				2'h1:    sig_byte = SIG1;
				2'h2:    sig_byte = SIG2;
				default: sig_byte = 8'h00;
			endcase
		end
	endfunction

	// Stored fuse byte for an index; index three reads zero.
	function [7:0] fuse_byte;
		input [1:0]  a;
		input [23:0] f;
		begin
			case (a)
				2'h0:    fuse_byte = f[7:0];
				2'h1:    fuse_byte = f[15:8];
				2'h2:    fuse_byte = f[23:16];
				default: fuse_byte = 8'h00;
			endcase
		end
	endfunction

	// ------------------------------------------------------------------
	// Protection level decode.
	// ------------------------------------------------------------------

	// Writes need both lock bits clear of programming.
	assign wr_ok = lock_ff[`LFSA_LOCK_HIGH_BIT] &
		lock_ff[`LFSA_LOCK_LOW_BIT];
	// Verification is lost only once the upper bit is programmed.
	assign rd_ok = lock_ff[`LFSA_LOCK_HIGH_BIT];

	// ------------------------------------------------------------------
	// Fuse bytes and their latching.
	// ------------------------------------------------------------------

	// Capture at power-up in normal mode and at programming entry, exit.
	assign capture = (pwrup_ff & ~prog_mode_i) |
		(prog_mode_i ^ prog_ff);

	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_fuse
			lfsa_fuse_latch #(
				.RST(FUSE_RST[8*g +: 8])
			) u_fuse (
				.mclk_i    (mclk_i),
				.arst_n_i  (arst_n_i),
				.wr_i      (fuse_wr[g]),
				.wdata_i   (rx_data),
				.capture_i (capture),
				.fuse_o    (fuse_st[8*g +: 8]),
				.live_o    (fuse_lv[8*g +: 8])
			);
		end
	endgenerate

	// Clock settings come from the latched low byte.
	assign clk_div8_o = fuse_lv[`LFSA_DIV8_BIT];
	assign startup_o  = fuse_lv[`LFSA_SUT_MSB:`LFSA_SUT_LSB];
	assign clk_src_o  = fuse_lv[`LFSA_CLOCK_SOURCE_FUSE_MSB:`LFSA_CLOCK_SOURCE_FUSE_LSB];

	// ------------------------------------------------------------------
	// Serial link.
	// ------------------------------------------------------------------
	lfsa_spi_shift u_shift (
		.mclk_i      (mclk_i),
		.arst_n_i    (arst_n_i),
		.en_i        (prog_mode_i),
		.sck_i       (sck_i),
		.mosi_i      (mosi_i),
		.load_i      (done),
		.load_data_i (reply),
		.rx_data_o   (rx_data),
		.done_o      (done),
		.miso_o      (miso_o)
	);

	// The third byte of a frame carries the data and runs the command.
	assign exec = done & (idx_ff == 2'h2);

	// ------------------------------------------------------------------
	// Command execution.
	// ------------------------------------------------------------------

	// Decide effects and the reply byte once the third byte of a frame is in.
	always @* begin
		nxt_lock    = lock_ff;
		nxt_refused = refused_ff;
		nxt_mem_wr  = 1'b0;
		nxt_erase   = 1'b0;
		fuse_wr     = 3'h0;
		reply       = 8'h00;
		if (exec) begin
			nxt_refused = 1'b0;
			case (cmd_ff)
				`LFSA_CMD_ERASE: begin
					nxt_erase = 1'b1;
					nxt_lock  = `LFSA_LOCK_RST;
				end
				`LFSA_CMD_WR_MEM: begin
					nxt_mem_wr  = wr_ok;
					nxt_refused = ~wr_ok;
					reply       = {7'h00, ~wr_ok};
				end
				`LFSA_CMD_RD_MEM: begin
					nxt_refused = ~rd_ok;
					reply       = rd_ok ? mem_rdata_i : 8'h00;
				end
				`LFSA_CMD_WR_FUSE: begin
					if (wr_ok && addr_ff[1:0] != 2'h3) begin
						fuse_wr[addr_ff[1:0]] = 1'b1;
					end
					nxt_refused = ~wr_ok;
					reply       = {7'h00, ~wr_ok};
				end
				`LFSA_CMD_RD_FUSE: begin
					reply = fuse_byte(addr_ff[1:0], fuse_st);
				end
				`LFSA_CMD_WR_LOCK: begin
					nxt_lock = lock_ff & rx_data;
				end
				`LFSA_CMD_RD_LOCK: begin
					reply = lock_ff;
				end
				`LFSA_CMD_RD_SIG: begin
					reply = sig_byte(addr_ff[1:0]);
				end
				default: begin
					nxt_refused = 1'b1;
				end
			endcase
		end else if (reg_wr_i && reg_addr_i == `LFSA_REG_LOCK &&
			spm_en_o) begin
			// Software may only program further lock bits.
			nxt_lock = lock_ff & reg_wdata_i;
		end
	end

	// ------------------------------------------------------------------
	// Frame tracking and memory strobes.
	// ------------------------------------------------------------------

	// Count bytes of the four-byte frame; a frame restarts with the mode.
	always @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			idx_ff      <= 2'h0;
			cmd_ff      <= 8'h00;
			addr_ff     <= 8'h00;
			refused_ff  <= 1'b0;
			lock_ff     <= `LFSA_LOCK_RST;
			mem_addr_o  <= 8'h00;
			mem_wdata_o <= 8'h00;
			mem_wr_o    <= 1'b0;
			mem_rd_o    <= 1'b0;
			mem_erase_o <= 1'b0;
		end else begin
			lock_ff     <= nxt_lock;
			refused_ff  <= nxt_refused;
			mem_wr_o    <= nxt_mem_wr;
			mem_erase_o <= nxt_erase;
			mem_rd_o    <= 1'b0;
			if (nxt_mem_wr) begin
				mem_wdata_o <= rx_data;
			end
			if (!prog_mode_i) begin
				idx_ff <= 2'h0;
			end else if (done) begin
				idx_ff <= idx_ff + 2'h1;
				if (idx_ff == 2'h0) begin
					cmd_ff <= rx_data;
				end
				if (idx_ff == 2'h1) begin
					addr_ff    <= rx_data;
					mem_addr_o <= rx_data;
					// Fetch early so the data is ready for the reply.
					mem_rd_o <= rd_ok &
						(cmd_ff == `LFSA_CMD_RD_MEM);
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Mode tracking and registered status outputs.
	// ------------------------------------------------------------------

	// Power-up marker lasts one cycle after reset release.
	always @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pwrup_ff      <= 1'b1;
			prog_ff       <= 1'b0;
			miso_oe_n_o   <= 1'b1;
			clkout_en_o   <= 1'b0;
			spm_en_o      <= 1'b0;
			ee_preserve_o <= 1'b0;
			prot_level_o  <= 2'h1;
		end else begin
			pwrup_ff    <= 1'b0;
			prog_ff     <= prog_mode_i;
			miso_oe_n_o <= ~prog_mode_i;
			// Programmed, i.e. zero, fuses turn features on.
			clkout_en_o   <= ~fuse_lv[`LFSA_CLOCK_OUTPUT_FUSE_BIT];
			spm_en_o      <= ~fuse_lv[16 + `LFSA_SELFPRG_BIT];
			// Preserve follows the stored byte, not the latched copy.
			ee_preserve_o <= ~fuse_st[8 + `LFSA_PRESERVE_BIT];
			if (wr_ok) begin
				prot_level_o <= 2'h1;
			end else if (rd_ok) begin
				prot_level_o <= 2'h2;
			end else begin
				prot_level_o <= 2'h3;
			end
		end
	end

	// ------------------------------------------------------------------
	// CPU register port.
	// ------------------------------------------------------------------

	// Read data stand for one cycle after the strobe, zero otherwise.
	always @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				`LFSA_REG_STATUS: begin
					reg_rdata_o <= {4'h0, prog_ff, refused_ff,
						prot_level_o};
				end
				`LFSA_REG_FUSE_LOW: begin
					reg_rdata_o <= fuse_lv[7:0];
				end
				`LFSA_REG_FUSE_HIGH: begin
					reg_rdata_o <= fuse_lv[15:8];
				end
				`LFSA_REG_FUSE_EXT: begin
					reg_rdata_o <= fuse_lv[23:16];
				end
				`LFSA_REG_LOCK: begin
					reg_rdata_o <= lock_ff;
				end
				`LFSA_REG_SIG0: begin
					reg_rdata_o <= sig_byte(2'h0);
				end
				`LFSA_REG_SIG1: begin
					reg_rdata_o <= sig_byte(2'h1);
				end
				`LFSA_REG_SIG2: begin
					reg_rdata_o <= sig_byte(2'h2);
				end
				default: begin
					reg_rdata_o <= 8'h00;
				end
			endcase
		end else begin
			reg_rdata_o <= 8'h00;
		end
	end

endmodule // lfsa_top
